/* logic/uiw_pkg.sv */
/*
 * Constants shared by the USB input path and wakeup register bank:
 * register offsets, field positions, reset values, class codes and timing.
 * Assumes an 8-bit register port and a single 125 MHz clock.
 */
package uiw_pkg;

    // Register port
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFS_PORT_RESULT = 8'h2f;
    localparam logic [7:0] OFS_PATH_HOLD   = 8'h30;
    localparam logic [7:0] OFS_WAKEUP      = 8'h31;

    // Reset values of whole registers
    localparam logic [7:0] RST_PORT_RESULT = 8'h20;
    localparam logic [7:0] RST_PATH_HOLD   = 8'h21;
    localparam logic [7:0] RST_WAKEUP      = 8'h03;

    // Charger port result fields
    localparam int unsigned CLASS_LSB = 5;
    localparam int unsigned CLASS_MSB = 7;
    localparam logic [2:0]  CLASS_SDP = 3'h1;
    localparam logic [2:0]  CLASS_CDP = 3'h2;
    localparam logic [2:0]  CLASS_DCP = 3'h3;

    // Input path and hold voltage fields
    localparam int unsigned PATH_DESEL_BIT = 7;
    localparam int unsigned HOLD_LSB       = 3;
    localparam int unsigned HOLD_MSB       = 5;
    localparam int unsigned ILIM_LSB       = 0;
    localparam int unsigned ILIM_MSB       = 1;
    localparam logic [2:0]  HOLD_RST       = 3'h4;
    localparam logic [1:0]  ILIM_RST       = 2'h1;
    localparam logic        DESEL_RST      = 1'b0;

    // Wakeup control fields
    localparam int unsigned PG_DRIVE_BIT  = 7;
    localparam int unsigned SOFT_WAKE_BIT = 5;
    localparam int unsigned IRQ_CTRL_BIT  = 4;
    localparam int unsigned WAKE_EN_BIT   = 3;
    localparam int unsigned VOFF_LSB      = 0;
    localparam int unsigned VOFF_MSB      = 2;
    localparam logic [2:0]  VOFF_RST      = 3'h3;

    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 8;
    localparam int unsigned WAKE_PERIOD_US = 100;
    localparam int unsigned WAKE_CYCLES_DEF =
        (WAKE_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_CNT_W = 24;

    // Synchronised pin inputs
    localparam int unsigned PIN_VBUS  = 0;
    localparam int unsigned PIN_SYSRST = 1;
    localparam int unsigned PIN_IRQ   = 2;
    localparam int unsigned PIN_N     = 3;

    typedef enum logic [1:0] {
        UIW_WAKE_IDLE   = 2'b01,
        UIW_WAKE_ACTIVE = 2'b10
    } uiw_wake_state_t;

endpackage

/* logic/uiw_sync.sv */
/*
 * Two flip-flop synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level; multi-bit coherence is not kept.
 */
`timescale 1ns/1ps
`default_nettype none

module uiw_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

/* logic/uiw_regs.sv */
/*
 * USB input path and output power wakeup register bank: charger port
 * result, input path / hold voltage / current limit, wakeup control.
 * Assumes a host register port on mclk, a detection engine on mclk,
 * and vbus_valid, sys_reset_n and irq_req arriving from pins.
 */
// The address-and-strobe port was chosen for this implementation.
//
// Contract
// - The detected port class is read-only in bits 7..5, 001 SDP, 010 CDP, 011 DCP.
// - A falling edge of VBUS returns the port result register to 20H, class 001.
// - The class is taken only when the detection busy flag falls from 1 to 0.
// - With VBUS valid the path is connected when bit 7 is 0 and cut when 1, reset 0.
// - Hold voltage code in bits 5..3 runs 4.0 V to 4.7 V in 0.1 V steps, reset 100.
// - For a non-SDP result bits 1..0 pick 900, 1500, 2000 or 2500 mA, reset 01.
// - Path register bit 7 resets on system reset, the rest on power-on only.
// - Wakeup register bit 3 resets on system reset, the rest on power-on, value 03H.
// - During an enabled wakeup power good is driven low only when bit 7 is 1.
// - Writing 1 to bit 5 wakes the output rails and the bit clears itself.
// - With bit 3 set, bit 4 governs the IRQ pin and whether IRQ can wake.
// - Bit 4 at 0 masks the IRQ pin and lets IRQ wake; at 1 the pin is normal, no wake.
// - Bit 3 enables wakeup from IRQ or soft wakeup and clears itself after use.
`timescale 1ns/1ps
`default_nettype none

module uiw_regs #(
    parameter int unsigned WAKE_CYCLES = uiw_pkg::WAKE_CYCLES_DEF
) (
    // Clock and power-on reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Pin levels from outside the clock domain
    input  wire logic        sys_reset_n,
    input  wire logic        vbus_valid,
    input  wire logic        irq_req,
    // Detection engine
    input  wire logic        detect_in_progress,
    input  wire logic [2:0]  detect_class,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Power path controls
    output logic             supply_path_connect,
    output logic      [2:0]  input_hold_voltage,
    output logic      [1:0]  current_limit_sel,
    output logic             current_limit_apply,
    output logic      [2:0]  voff_setting,
    // Wakeup
    output logic             rails_wakeup,
    output logic             power_good_out_low,
    output logic             irq_pin_mask
);

    logic                          rst_meta;
    logic                          rst_n;
    logic [uiw_pkg::PIN_N-1:0]     pins_s;
    logic                          vbus_s;
    logic                          vbus_prev;
    logic                          vbus_fall;
    logic                          sys_rst;
    logic                          irq_s;
    logic                          det_prev;
    logic                          det_fall;
    logic [2:0]                    charger_port_class;
    logic                          supply_path_deselect;
    logic [2:0]                    hold_code;
    logic [1:0]                    ilim_code;
    logic                          pg_drive;
    logic                          soft_wake;
    logic                          irq_ctrl;
    logic                          wake_en;
    logic [2:0]                    voff;
    logic                          wr_path;
    logic                          wr_wake;
    logic                          irq_trigger;
    logic                          wake_start;
    logic                          wake_done;
    uiw_pkg::uiw_wake_state_t      wake_state;
    logic [uiw_pkg::WAKE_CNT_W-1:0] wake_cnt;
    logic [7:0]                    next_rdata;

    localparam logic [uiw_pkg::WAKE_CNT_W-1:0] WAKE_LAST =
        uiw_pkg::WAKE_CNT_W'(WAKE_CYCLES - 1);

    // Power-on reset release
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    uiw_sync #(
        .WIDTH (uiw_pkg::PIN_N)
    ) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in ({irq_req, ~sys_reset_n, vbus_valid}),
        .sync_out (pins_s)
    );

    assign vbus_s  = pins_s[uiw_pkg::PIN_VBUS];
    assign sys_rst = pins_s[uiw_pkg::PIN_SYSRST];
    assign irq_s   = pins_s[uiw_pkg::PIN_IRQ];

    // Edge history
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vbus_prev <= 1'b0;
            det_prev  <= 1'b0;
        end else begin
            vbus_prev <= vbus_s;
            det_prev  <= detect_in_progress;
        end
    end

    assign vbus_fall = vbus_prev & ~vbus_s;
    assign det_fall  = det_prev & ~detect_in_progress;
    assign wr_path   = reg_wr && (reg_addr == uiw_pkg::OFS_PATH_HOLD);
    assign wr_wake   = reg_wr && (reg_addr == uiw_pkg::OFS_WAKEUP);

    // Port result: VBUS removal beats a detection finishing in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            charger_port_class <= uiw_pkg::CLASS_SDP;
        end else if (vbus_fall) begin
            charger_port_class <= uiw_pkg::CLASS_SDP;
        end else if (det_fall) begin
            charger_port_class <= detect_class;
        end
    end

    // Path deselect, system-reset domain
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            supply_path_deselect <= uiw_pkg::DESEL_RST;
        end else if (sys_rst) begin
            supply_path_deselect <= uiw_pkg::DESEL_RST;
        end else if (wr_path) begin
            supply_path_deselect <= reg_wdata[uiw_pkg::PATH_DESEL_BIT];
        end
    end

    // Hold voltage and current limit survive a system reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_code <= uiw_pkg::HOLD_RST;
            ilim_code <= uiw_pkg::ILIM_RST;
        end else if (wr_path) begin
            hold_code <= reg_wdata[uiw_pkg::HOLD_MSB:uiw_pkg::HOLD_LSB];
            ilim_code <= reg_wdata[uiw_pkg::ILIM_MSB:uiw_pkg::ILIM_LSB];
        end
    end

    // Power-on-only wakeup fields
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pg_drive <= 1'b0;
            irq_ctrl <= 1'b0;
            voff     <= uiw_pkg::VOFF_RST;
        end else if (wr_wake) begin
            pg_drive <= reg_wdata[uiw_pkg::PG_DRIVE_BIT];
            irq_ctrl <= reg_wdata[uiw_pkg::IRQ_CTRL_BIT];
            voff     <= reg_wdata[uiw_pkg::VOFF_MSB:uiw_pkg::VOFF_LSB];
        end
    end

    // Soft wakeup request lives one cycle and then clears itself
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            soft_wake <= 1'b0;
        end else begin
            soft_wake <= wr_wake & reg_wdata[uiw_pkg::SOFT_WAKE_BIT];
        end
    end

    // Wakeup enable: a fresh write of 1 beats the self-clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wake_en <= 1'b0;
        end else if (sys_rst) begin
            wake_en <= 1'b0;
        end else if (wr_wake) begin
            wake_en <= reg_wdata[uiw_pkg::WAKE_EN_BIT];
        end else if (wake_done) begin
            wake_en <= 1'b0;
        end
    end

    assign irq_trigger = wake_en & ~irq_ctrl & irq_s;
    assign wake_start  = (wake_state == uiw_pkg::UIW_WAKE_IDLE) && wake_en &&
                         (soft_wake || irq_trigger);
    assign wake_done   = (wake_state == uiw_pkg::UIW_WAKE_ACTIVE) && (wake_cnt == WAKE_LAST);

    // Wakeup period
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wake_state <= uiw_pkg::UIW_WAKE_IDLE;
            wake_cnt   <= '0;
        end else begin
            case (wake_state)
                uiw_pkg::UIW_WAKE_IDLE: begin
                    wake_cnt <= '0;
                    if (wake_start) begin
                        wake_state <= uiw_pkg::UIW_WAKE_ACTIVE;
                    end
                end
                uiw_pkg::UIW_WAKE_ACTIVE: begin
                    wake_cnt <= wake_cnt + 1'b1;
                    if (wake_done) begin
                        wake_state <= uiw_pkg::UIW_WAKE_IDLE;
                    end
                end
                default: begin
                    wake_state <= uiw_pkg::UIW_WAKE_IDLE;
                    wake_cnt   <= '0;
                end
            endcase
        end
    end

    // Registered control outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            supply_path_connect <= 1'b0;
            input_hold_voltage  <= uiw_pkg::HOLD_RST;
            current_limit_sel   <= uiw_pkg::ILIM_RST;
            current_limit_apply <= 1'b0;
            voff_setting        <= uiw_pkg::VOFF_RST;
        end else begin
            supply_path_connect <= vbus_s & ~supply_path_deselect;
            input_hold_voltage  <= hold_code;
            current_limit_sel   <= ilim_code;
            current_limit_apply <= charger_port_class != uiw_pkg::CLASS_SDP;
            voff_setting        <= voff;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rails_wakeup       <= 1'b0;
            power_good_out_low <= 1'b0;
            irq_pin_mask       <= 1'b0;
        end else begin
            rails_wakeup       <= wake_state == uiw_pkg::UIW_WAKE_ACTIVE;
            power_good_out_low <= (wake_state == uiw_pkg::UIW_WAKE_ACTIVE) & pg_drive;
            irq_pin_mask       <= wake_en & ~irq_ctrl;
        end
    end

    // Read mux; holes stay zero
    always_comb begin
        next_rdata = '0;
        case (reg_addr)
            uiw_pkg::OFS_PORT_RESULT: begin
                next_rdata[uiw_pkg::CLASS_MSB:uiw_pkg::CLASS_LSB] = charger_port_class;
            end
            uiw_pkg::OFS_PATH_HOLD: begin
                next_rdata[uiw_pkg::PATH_DESEL_BIT]               = supply_path_deselect;
                next_rdata[uiw_pkg::HOLD_MSB:uiw_pkg::HOLD_LSB]   = hold_code;
                next_rdata[uiw_pkg::ILIM_MSB:uiw_pkg::ILIM_LSB]   = ilim_code;
            end
            uiw_pkg::OFS_WAKEUP: begin
                next_rdata[uiw_pkg::PG_DRIVE_BIT]                 = pg_drive;
                next_rdata[uiw_pkg::SOFT_WAKE_BIT]                = soft_wake;
                next_rdata[uiw_pkg::IRQ_CTRL_BIT]                 = irq_ctrl;
                next_rdata[uiw_pkg::WAKE_EN_BIT]                  = wake_en;
                next_rdata[uiw_pkg::VOFF_MSB:uiw_pkg::VOFF_LSB]   = voff;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= '0;
        end
    end

    // Checks
    sequence s_soft_pulse;
        soft_wake ##1 !soft_wake;
    endsequence
    sequence s_wake_run;
        rails_wakeup [*8];
    endsequence

    property p_class_fall;
        @(posedge mclk) disable iff (!rst_n)
        vbus_fall |=> charger_port_class == uiw_pkg::CLASS_SDP;
    endproperty
    a_class_fall: assert property (p_class_fall) else $error("class not reset by vbus fall");

    property p_class_take;
        @(posedge mclk) disable iff (!rst_n)
        det_fall && !vbus_fall |=> charger_port_class == $past(detect_class);
    endproperty
    a_class_take: assert property (p_class_take) else $error("class not taken at end");

    property p_class_hold;
        @(posedge mclk) disable iff (!rst_n)
        !det_fall && !vbus_fall |=> $stable(charger_port_class);
    endproperty
    a_class_hold: assert property (p_class_hold) else $error("class moved without cause");

    property p_path;
        @(posedge mclk) disable iff (!rst_n)
        ##1 supply_path_connect == $past(vbus_s & ~supply_path_deselect);
    endproperty
    a_path: assert property (p_path) else $error("path connect wrong");

    property p_sysrst;
        @(posedge mclk) disable iff (!rst_n)
        sys_rst |=> !supply_path_deselect && !wake_en && $stable(hold_code)
                    && $stable(ilim_code) && $stable(pg_drive);
    endproperty
    a_sysrst: assert property (p_sysrst) else $error("system reset scope wrong");

    property p_ilim;
        @(posedge mclk) disable iff (!rst_n)
        ##1 current_limit_apply == ($past(charger_port_class) != uiw_pkg::CLASS_SDP);
    endproperty
    a_ilim: assert property (p_ilim) else $error("current limit apply wrong");

    property p_soft;
        @(posedge mclk) disable iff (!rst_n)
        wr_wake && reg_wdata[uiw_pkg::SOFT_WAKE_BIT] |=> s_soft_pulse;
    endproperty
    a_soft: assert property (p_soft) else $error("soft wakeup not self clearing");

    property p_wake_run;
        @(posedge mclk) disable iff (!rst_n)
        wake_start |=> ##1 s_wake_run;
    endproperty
    a_wake_run: assert property (p_wake_run) else $error("wakeup period cut short");

    property p_no_wake;
        @(posedge mclk) disable iff (!rst_n)
        !wake_en |-> !wake_start;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("wakeup while disabled");

    property p_pg;
        @(posedge mclk) disable iff (!rst_n)
        ##1 power_good_out_low == (rails_wakeup && $past(pg_drive));
    endproperty
    a_pg: assert property (p_pg) else $error("power good drive wrong");

    property p_irq_mask;
        @(posedge mclk) disable iff (!rst_n)
        wake_en && irq_ctrl && !soft_wake && wake_state == uiw_pkg::UIW_WAKE_IDLE |-> !wake_start;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq woke while normal");

    property p_rsvd;
        @(posedge mclk) disable iff (!rst_n)
        reg_rd && reg_addr == uiw_pkg::OFS_PORT_RESULT |=> reg_rdata[4:0] == 5'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

endmodule

`default_nettype wire

/* verification/uiw_det_model.sv */
/*
 * Behavioural model of the charger detection engine beside the register bank.
 * Assumes the bench pulses start for one cycle and holds cls until busy ends.
 */
`timescale 1ns/1ps
`default_nettype none

module uiw_det_model #(
    parameter int unsigned BUSY_CYCLES = 8
) (
    // Clock
    input  wire logic       mclk,
    // Bench control
    input  wire logic       start,
    input  wire logic [2:0] cls,
    // Towards the register bank
    output var  logic       detect_in_progress,
    output var  logic [2:0] detect_class
);
    logic [3:0] left  = 4'h0;
    logic [3:0] tail  = 4'h0;
    logic [2:0] noise = 3'h0;

    always_ff @(posedge mclk) begin
        noise <= noise + 3'h3;
    end

    always_ff @(posedge mclk) begin
        if (start) begin
            left <= 4'(BUSY_CYCLES);
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
        tail <= (left == 4'h1) ? 4'h3 : ((tail != 4'h0) ? tail - 4'h1 : 4'h0);
    end

    assign detect_in_progress = (left != 4'h0);
    // Class is only trustworthy around the busy fall; junk elsewhere exposes early sampling
    assign detect_class = ((left == 4'h1) || (tail != 4'h0)) ? cls : ~noise;
endmodule

`default_nettype wire

/* verification/tb.sv */
/*
 * Self-checking bench for the input path and wakeup register bank.
 * Assumes the register port answers reads one cycle after the strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int unsigned WC = 16;

    logic       mclk;
    logic       resetn;
    logic       sys_reset_n;
    logic       vbus_valid;
    logic       irq_req;
    logic       det_start;
    logic [2:0] det_cls;
    logic       detect_in_progress;
    logic [2:0] detect_class;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       supply_path_connect;
    logic [2:0] input_hold_voltage;
    logic [1:0] current_limit_sel;
    logic       current_limit_apply;
    logic [2:0] voff_setting;
    logic       rails_wakeup;
    logic       power_good_out_low;
    logic       irq_pin_mask;
    int         mismatches;
    int         compares;
    int         n;
    logic [7:0] d;

    uiw_regs #(.WAKE_CYCLES(WC)) dut (
        .mclk(mclk), .resetn(resetn), .sys_reset_n(sys_reset_n),
        .vbus_valid(vbus_valid), .irq_req(irq_req),
        .detect_in_progress(detect_in_progress), .detect_class(detect_class),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .supply_path_connect(supply_path_connect),
        .input_hold_voltage(input_hold_voltage), .current_limit_sel(current_limit_sel),
        .current_limit_apply(current_limit_apply), .voff_setting(voff_setting),
        .rails_wakeup(rails_wakeup), .power_good_out_low(power_good_out_low),
        .irq_pin_mask(irq_pin_mask)
    );

    uiw_det_model #(.BUSY_CYCLES(8)) det (
        .mclk(mclk), .start(det_start), .cls(det_cls),
        .detect_in_progress(detect_in_progress), .detect_class(detect_class)
    );

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic chk_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        chk_pin($sformatf("reg %h", a), e, reg_rdata);
    endtask

    // Runs one detection and checks the result stays hidden until busy falls
    task automatic detect(input logic [2:0] c, input logic [7:0] prev);
        @(posedge mclk);
        det_cls   <= c;
        det_start <= 1'b1;
        @(posedge mclk);
        det_start <= 1'b0;
        chk_reg(uiw_pkg::OFS_PORT_RESULT, prev);
        for (int i = 0; i < 20 && detect_in_progress === 1'b1; i++) @(posedge mclk);
        idle(3);
        chk_reg(uiw_pkg::OFS_PORT_RESULT, {c, 5'h00});
        chk_pin("apply", {7'h0, c != uiw_pkg::CLASS_SDP}, {7'h0, current_limit_apply});
    endtask

    // Waits for a wakeup, then checks its length and the power-good drive
    task automatic wake(input logic pg);
        n = 0;
        for (int i = 0; i < 30 && rails_wakeup !== 1'b1; i++) @(negedge mclk);
        while (rails_wakeup === 1'b1 && n < 100) begin
            chk_pin("pg_low", {7'h0, pg}, {7'h0, power_good_out_low});
            n++;
            @(negedge mclk);
        end
        chk_pin("wake_len", 8'(WC), n[7:0]);
    endtask

    initial begin
        #300000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        resetn      = 1'b0;
        sys_reset_n = 1'b1;
        vbus_valid  = 1'b1;
        irq_req     = 1'b0;
        det_start   = 1'b0;
        det_cls     = 3'h0;
        reg_addr    = 8'h00;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        mismatches  = 0;
        compares    = 0;
        idle(20);
        resetn <= 1'b1;
        idle(5);
        chk_reg(uiw_pkg::OFS_PORT_RESULT, 8'h20);
        chk_reg(uiw_pkg::OFS_PATH_HOLD, 8'h21);
        chk_reg(uiw_pkg::OFS_WAKEUP, 8'h03);
        chk_pin("hold", 8'h04, {5'h0, input_hold_voltage});
        chk_pin("ilim", 8'h01, {6'h0, current_limit_sel});
        chk_pin("voff", 8'h03, {5'h0, voff_setting});
        chk_pin("connect", 8'h01, {7'h0, supply_path_connect});
        chk_reg(8'h40, 8'h00);
        wr(uiw_pkg::OFS_PORT_RESULT, 8'hff);
        chk_reg(uiw_pkg::OFS_PORT_RESULT, 8'h20);
        wr(uiw_pkg::OFS_PATH_HOLD, 8'hff);
        chk_reg(uiw_pkg::OFS_PATH_HOLD, 8'hbb);
        chk_pin("connect", 8'h00, {7'h0, supply_path_connect});
        for (int i = 0; i < 8; i++) begin
            wr(uiw_pkg::OFS_PATH_HOLD, 8'(i << 3) | 8'(i % 4));
            idle(2);
            chk_pin("hold", 8'(i), {5'h0, input_hold_voltage});
            chk_pin("ilim", 8'(i % 4), {6'h0, current_limit_sel});
        end
        chk_pin("connect", 8'h01, {7'h0, supply_path_connect});
        detect(uiw_pkg::CLASS_SDP, 8'h20);
        detect(uiw_pkg::CLASS_CDP, 8'h20);
        detect(uiw_pkg::CLASS_DCP, 8'h40);
        @(posedge mclk);
        vbus_valid <= 1'b0;
        idle(6);
        chk_reg(uiw_pkg::OFS_PORT_RESULT, 8'h20);
        chk_pin("connect", 8'h00, {7'h0, supply_path_connect});
        chk_pin("apply", 8'h00, {7'h0, current_limit_apply});
        @(posedge mclk);
        vbus_valid <= 1'b1;
        wr(uiw_pkg::OFS_PATH_HOLD, 8'hb9);
        wr(uiw_pkg::OFS_WAKEUP, 8'h98);
        sys_reset_n <= 1'b0;
        idle(6);
        sys_reset_n <= 1'b1;
        idle(6);
        chk_reg(uiw_pkg::OFS_PATH_HOLD, 8'h39);
        chk_reg(uiw_pkg::OFS_WAKEUP, 8'h90);
        chk_pin("voff", 8'h00, {5'h0, voff_setting});
        wr(uiw_pkg::OFS_WAKEUP, 8'ha8);
        wake(1'b1);
        idle(2);
        chk_reg(uiw_pkg::OFS_WAKEUP, 8'h80);
        wr(uiw_pkg::OFS_WAKEUP, 8'h28);
        wake(1'b0);
        wr(uiw_pkg::OFS_WAKEUP, 8'h08);
        idle(2);
        chk_pin("irq_mask", 8'h01, {7'h0, irq_pin_mask});
        irq_req <= 1'b1;
        wake(1'b0);
        @(posedge mclk);
        irq_req <= 1'b0;
        wr(uiw_pkg::OFS_WAKEUP, 8'h18);
        idle(2);
        chk_pin("irq_mask", 8'h00, {7'h0, irq_pin_mask});
        irq_req <= 1'b1;
        n = 0;
        repeat (40) begin
            @(negedge mclk);
            n = n + ((rails_wakeup === 1'b0) ? 0 : 1);
        end
        chk_pin("irq_wake", 8'h00, n[7:0]);
        @(posedge mclk);
        irq_req <= 1'b0;
        report_and_stop();
    end
endmodule

`default_nettype wire
